//--- verilog/tfd_pkg.sv
package tfd_pkg;
    // Register byte addresses
    localparam logic [11:0] ADDR_POWER = 12'h000;
    localparam logic [11:0] ADDR_MODE = 12'h004;
    localparam logic [11:0] ADDR_PERIOD = 12'h008;
    localparam logic [11:0] ADDR_COUNT = 12'h00C;
    localparam logic [11:0] ADDR_TRIG = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;
    localparam logic [11:0] ADDR_OUTCTL = 12'h018;
    // Mode register fields
    localparam int MODE_START_SEL_BIT = 0;
    localparam int MODE_EDGE_LSB = 1;
    // Edge select codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    // Trigger register fields
    localparam int TRIG_START_BIT = 0;
    localparam int TRIG_STOP_BIT = 1;
    // Output control fields
    localparam int OUT_LEVEL_BIT = 0;
    localparam int OUT_ENABLE_BIT = 1;
    localparam int OUT_MODE_BIT = 2;
    localparam int OUT_POL_BIT = 3;
    // Reset values and the counter's zero compare value
    localparam logic [15:0] PERIOD_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
endpackage

//--- verilog/tfd_top.sv
// Notes on behaviour
// [R01] Single channel: input pin in, output pin out
// [R02] Single edge: fout = fin / (2*(period+1))
// [R03] Both edges: fout about fin/(period+1)
// [R04] Count register counts down
// [R05] First valid edge after start loads period
// [R06] Start select 0: load gives no event
// [R07] Start select 1: load toggles and interrupts
// [R08] Decrement per edge; at zero toggle, reload
// [R09] Interrupt pulses with every zero toggle
// [R10] Output period jitters by one clock
// [R11] New period used from next reload
// [R12] Start trigger sets run status, self-clears
// [R13] Stop trigger halts, counter holds value
// [R14] Stopping leaves output level unchanged
// [R15] Stopped, enabled: pin shows level bit
// [R16] Software keeps mode fixed while running
// [R17] Software sets master mode before start
// [R18] Power off: registers other than power ignore all access
// [R19] Power off resets channel and output
// [R20] Mode selects rising, falling or both
// [R21] Input synchronised, one event per edge
`timescale 1ns/10ps
module tfd_top
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link pins
    input wire logic divider_input_pin,
    output logic divided_output,
    output logic divided_output_oe,
    output logic channel_interrupt
);
    logic unit_power_enable_r;
    logic [2:0] channel_mode_reg_r;
    logic [15:0] period_data_reg_r;
    logic [15:0] channel_down_counter_r;
    logic channel_run_status_r;
    logic loaded_r;
    logic out_level_r;
    logic output_enable_bit_r;
    logic output_mode_bit_r;
    logic output_polarity_bit_r;
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic pin_out_r;
    logic pin_oe_r;
    logic irq_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    logic access;
    logic wr;
    logic known;
    logic rise;
    logic fall;
    logic valid_edge;
    logic start_sel;
    logic [1:0] edge_sel;
    logic start_trig;
    logic stop_trig;
    logic zero_event;
    logic load_event;
    logic toggle;

    assign access = psel && penable && !pready_r;
    assign wr = access && pwrite;
    assign known = paddr == tfd_pkg::ADDR_POWER
        || paddr == tfd_pkg::ADDR_MODE
        || paddr == tfd_pkg::ADDR_PERIOD
        || paddr == tfd_pkg::ADDR_COUNT
        || paddr == tfd_pkg::ADDR_TRIG
        || paddr == tfd_pkg::ADDR_STATUS
        || paddr == tfd_pkg::ADDR_OUTCTL;
    assign start_sel = channel_mode_reg_r[tfd_pkg::MODE_START_SEL_BIT];
    assign edge_sel = channel_mode_reg_r[tfd_pkg::MODE_EDGE_LSB +: 2];
    // Triggers are write strobes only, so they read back zero
    assign start_trig = wr && unit_power_enable_r
        && paddr == tfd_pkg::ADDR_TRIG
        && pwdata[tfd_pkg::TRIG_START_BIT]; // [R12]
    assign stop_trig = wr && unit_power_enable_r
        && paddr == tfd_pkg::ADDR_TRIG
        && pwdata[tfd_pkg::TRIG_STOP_BIT]; // [R13]

    // Edge detect on the second stage only
    assign rise = sync2_r && !prev_r; // [R21]
    assign fall = !sync2_r && prev_r; // [R21]
    always_comb
    begin
        unique case (edge_sel) // [R20]
            tfd_pkg::EDGE_RISE: valid_edge = rise;
            tfd_pkg::EDGE_FALL: valid_edge = fall;
            default: valid_edge = rise || fall; // [R03]
        endcase
    end

    // Counting only while running; stop wins over a same-cycle edge
    assign load_event = channel_run_status_r && !stop_trig
        && valid_edge && !loaded_r; // [R05]
    assign zero_event = channel_run_status_r && !stop_trig
        && valid_edge && loaded_r
        && channel_down_counter_r == tfd_pkg::COUNT_ZERO; // [R08]
    assign toggle = zero_event || (load_event && start_sel); // [R06] [R07]

    // Input synchroniser; sampling costs up to one clock of jitter
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            sync1_r <= divider_input_pin; // [R21]
            sync2_r <= sync1_r;
            prev_r <= sync2_r; // [R10]
        end
    end

    // Unit power enable: clearing it resets the whole channel
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            unit_power_enable_r <= 1'b0;
        else if (wr && paddr == tfd_pkg::ADDR_POWER)
            unit_power_enable_r <= pwdata[0];
    end

    // Configuration registers
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            channel_mode_reg_r <= tfd_pkg::MODE_RST;
            period_data_reg_r <= tfd_pkg::PERIOD_RST;
            out_level_r <= 1'b0;
            output_enable_bit_r <= 1'b0;
            output_mode_bit_r <= 1'b0;
            output_polarity_bit_r <= 1'b0;
        end
        else if (!unit_power_enable_r)
        begin
            channel_mode_reg_r <= tfd_pkg::MODE_RST; // [R19]
            period_data_reg_r <= tfd_pkg::PERIOD_RST;
            out_level_r <= 1'b0; // [R19]
            output_enable_bit_r <= 1'b0;
            output_mode_bit_r <= 1'b0;
            output_polarity_bit_r <= 1'b0;
        end
        else
        begin
            if (wr && paddr == tfd_pkg::ADDR_MODE)
                channel_mode_reg_r <= pwdata[2:0];
            // Held here; the counter only picks it up on reload
            if (wr && paddr == tfd_pkg::ADDR_PERIOD)
                period_data_reg_r <= pwdata[15:0]; // [R11]
            if (wr && paddr == tfd_pkg::ADDR_OUTCTL)
            begin
                output_enable_bit_r <= pwdata[tfd_pkg::OUT_ENABLE_BIT];
                output_mode_bit_r <= pwdata[tfd_pkg::OUT_MODE_BIT];
                output_polarity_bit_r <= pwdata[tfd_pkg::OUT_POL_BIT];
            end
            // Hardware toggle wins over a same-cycle software write
            if (toggle)
                out_level_r <= !out_level_r; // [R08] [R14]
            else if (wr && paddr == tfd_pkg::ADDR_OUTCTL)
                out_level_r <= pwdata[tfd_pkg::OUT_LEVEL_BIT];
        end
    end

    // Run status and counter
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            channel_run_status_r <= 1'b0;
            loaded_r <= 1'b0;
            channel_down_counter_r <= tfd_pkg::COUNT_RST;
        end
        else if (!unit_power_enable_r)
        begin
            channel_run_status_r <= 1'b0; // [R19]
            loaded_r <= 1'b0;
            channel_down_counter_r <= tfd_pkg::COUNT_RST;
        end
        else
        begin
            if (stop_trig)
                channel_run_status_r <= 1'b0; // [R13]
            else if (start_trig)
                channel_run_status_r <= 1'b1; // [R12]
            if (start_trig && !stop_trig)
                loaded_r <= 1'b0; // [R05]
            else if (load_event)
                loaded_r <= 1'b1;
            if (load_event || zero_event)
                channel_down_counter_r <= period_data_reg_r; // [R05] [R08]
            else if (channel_run_status_r && !stop_trig && valid_edge)
                channel_down_counter_r <=
                    channel_down_counter_r - 16'h0001; // [R04] [R02]
        end
    end

    // Pin and interrupt, all from flops
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            // Pin follows the level bit, stopped or running
            pin_out_r <= out_level_r; // [R01] [R15]
            pin_oe_r <= unit_power_enable_r && output_enable_bit_r; // [R19]
            irq_r <= unit_power_enable_r && toggle; // [R09] [R07]
        end
    end

    // APB answer: one wait state, always ready on the second access cycle
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= access;
            pslverr_r <= access && !known;
            prdata_r <= 32'h0000_0000;
            if (access && !pwrite && paddr == tfd_pkg::ADDR_POWER)
                prdata_r <= {31'h0, unit_power_enable_r};
            else if (access && !pwrite && unit_power_enable_r) // [R18]
            begin
                unique case (paddr)
                    tfd_pkg::ADDR_MODE:
                        prdata_r <= {29'h0, channel_mode_reg_r};
                    tfd_pkg::ADDR_PERIOD:
                        prdata_r <= {16'h0, period_data_reg_r};
                    tfd_pkg::ADDR_COUNT:
                        prdata_r <= {16'h0, channel_down_counter_r};
                    tfd_pkg::ADDR_STATUS:
                        prdata_r <= {31'h0, channel_run_status_r};
                    tfd_pkg::ADDR_OUTCTL:
                        prdata_r <= {28'h0, output_polarity_bit_r,
                            output_mode_bit_r, output_enable_bit_r,
                            out_level_r};
                    default:
                        prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign divided_output = pin_out_r;
    assign divided_output_oe = pin_oe_r;
    assign channel_interrupt = irq_r;
endmodule // tfd_top

//--- test/tfd_clk_src.sv
`timescale 1ns/10ps
module tfd_clk_src
(
    // Clock
    input wire logic ref_clk,
    // Burst control
    input wire logic run,
    input wire logic [7:0] half,
    // Source pin
    output logic pin
);
    logic [7:0] cnt_r = 8'h00;
    logic pin_r = 1'b0;
    assign pin = pin_r;
    // Between bursts the line stands still at its last level
    always_ff @(posedge ref_clk)
        cnt_r <= (!run || cnt_r == half - 8'h01) ? 8'h00 : cnt_r + 8'h01;
    always_ff @(posedge ref_clk)
        if (run && cnt_r == half - 8'h01)
            pin_r <= ~pin_r;
endmodule // tfd_clk_src

//--- test/tfd_top_monitor.sv
`timescale 1ns/10ps
module tfd_top_monitor
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic divider_input_pin,
    input wire logic divided_output,
    input wire logic divided_output_oe,
    input wire logic channel_interrupt
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_acc;
        psel && penable && !pready;
    endsequence
    property p_rdy; s_acc |=> pready; endproperty
    a_rdy: assert property (p_rdy)
        else $error("pready late");
    property p_rdy1; pready |=> !pready; endproperty
    a_rdy1: assert property (p_rdy1)
        else $error("pready long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err)
        else $error("pslverr alone");
    property p_irq1; channel_interrupt |=> !channel_interrupt; endproperty
    a_irq1: assert property (p_irq1)
        else $error("irq long");
    // Sync and edge stages put the event 3 clocks behind the pin; the check accepts 3 to 6
    property p_irqin; channel_interrupt |->
        $past(divider_input_pin, 3) != $past(divider_input_pin, 7);
    endproperty
    a_irqin: assert property (p_irqin)
        else $error("irq without edge");
    property p_tog;
        channel_interrupt |-> ##[0:2] $changed(divided_output);
    endproperty
    a_tog: assert property (p_tog)
        else $error("irq without toggle");
    property p_cause; $changed(divided_output) |-> ($past(psel && pwrite)
        || $past(psel && pwrite, 2) || channel_interrupt
        || $past(channel_interrupt)) or ##1 channel_interrupt;
    endproperty
    a_cause: assert property (p_cause)
        else $error("pin moved alone");
    property p_oe; $changed(divided_output_oe) |->
        $past(psel && pwrite) || $past(psel && pwrite, 2);
    endproperty
    a_oe: assert property (p_oe)
        else $error("oe moved alone");
endmodule // tfd_top_monitor
bind tfd_top tfd_top_monitor u_tfd_top_monitor (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr),
    .divider_input_pin(divider_input_pin), .divided_output(divided_output),
    .divided_output_oe(divided_output_oe),
    .channel_interrupt(channel_interrupt));

//--- test/timer_frequency_divider_tb.sv
`timescale 1ns/10ps
module timer_frequency_divider_tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic run = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0] half = 8'h08;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, dout, doe, irq, pin;
    int mismatches = 0;
    int comparisons = 0;
    int irqs, togs, p, k, e, s, m, v;
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        irqs += int'(irq === 1'b1);
        togs += int'($changed(dout));
    end
    tfd_top u_tfd_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .divider_input_pin(pin), .divided_output(dout),
        .divided_output_oe(doe), .channel_interrupt(irq));
    tfd_clk_src u_tfd_clk_src (.ref_clk(ref_clk), .run(run), .half(half),
        .pin(pin));
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic chk(input string t, input logic [31:0] x, y);
        comparisons++;
        if (y !== x)
            $display("Error %s expected %h seen %h", t, x, y);
        if (y !== x)
            mismatches++;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), x, rd);
    endtask
    // Whole halves only, so the line ends at a known level
    task automatic burst(input int n);
        run <= 1'b1;
        repeat (n * half) @(posedge ref_clk);
        run <= 1'b0;
        repeat (12) @(posedge ref_clk);
    endtask
    function automatic int exp_ev(int sv, int pv, int ev);
        return sv + (ev - 1) / (pv + 1);
    endfunction
    function automatic int exp_cnt(int pv, int ev);
        return pv - (ev - 1) % (pv + 1);
    endfunction
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #50000;
        mismatches++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'h340B5490));
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b1, tfd_pkg::ADDR_PERIOD, 32'h5);
        apb(1'b1, tfd_pkg::ADDR_POWER, 32'h1);
        rchk(tfd_pkg::ADDR_PERIOD, 32'(tfd_pkg::PERIOD_RST));
        apb(1'b0, 12'h020, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        for (int i = 0; i < 6; i++)
        begin
            m = i / 2;
            s = i % 2;
            p = $urandom_range(3, 0);
            k = $urandom_range(8, 4);
            half <= 8'($urandom_range(11, 8));
            apb(1'b1, tfd_pkg::ADDR_POWER, 32'h1);
            rchk(tfd_pkg::ADDR_OUTCTL, 32'h0);
            apb(1'b1, tfd_pkg::ADDR_MODE, 32'(m * 2 + s));
            apb(1'b1, tfd_pkg::ADDR_PERIOD, 32'(p));
            apb(1'b1, tfd_pkg::ADDR_OUTCTL, 32'h2);
            apb(1'b1, tfd_pkg::ADDR_TRIG, 32'h1);
            rchk(tfd_pkg::ADDR_STATUS, 32'h1);
            rchk(tfd_pkg::ADDR_TRIG, 32'h0);
            irqs = 0;
            togs = 0;
            burst(2 * k - 1);
            e = (m == 2) ? 2 * k - 1 : k - m;
            v = exp_ev(s, p, e);
            chk("irqs", v, irqs);
            chk("toggles", v, togs);
            rchk(tfd_pkg::ADDR_COUNT, exp_cnt(p, e));
            apb(1'b1, tfd_pkg::ADDR_TRIG, 32'h2);
            rchk(tfd_pkg::ADDR_STATUS, 32'h0);
            burst(3);
            rchk(tfd_pkg::ADDR_COUNT, exp_cnt(p, e));
            chk("irqs stopped", v, irqs);
            chk("pins held", 32'(2 + v % 2), 32'({doe, dout}));
            apb(1'b1, tfd_pkg::ADDR_OUTCTL, 32'(3 - v % 2));
            repeat (2) @(posedge ref_clk);
            chk("pins level", 32'(3 - v % 2), 32'({doe, dout}));
            apb(1'b1, tfd_pkg::ADDR_POWER, 32'h0);
            repeat (2) @(posedge ref_clk);
            chk("pins off", 32'h0, 32'({doe, dout}));
        end
        report_and_stop();
    end
endmodule // timer_frequency_divider_tb
